// File: uoi_flags.sv
// USB OTG interrupt status, enable and line timing logic with a Wishbone slave.
`timescale 1ns/1ps
`default_nettype none
module uoi_flags #(
  parameter int IDLE_CYC = uoi_pkg::IDLE_CYC,
  parameter int MS_CYC = uoi_pkg::MS_CYC,
  parameter int KSTATE_CYC = uoi_pkg::KSTATE_CYC
) (
  input wire logic core_clk, // Module clock, 200 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic dp_i, // D+ line level, asynchronous.
  input wire logic dm_i, // D- line level, asynchronous.
  input wire logic id_i, // ID pin level, asynchronous.
  input wire logic a_vbus_vld_i, // A-device VBUS valid comparator, asynchronous.
  input wire logic sess_vld_i, // Session valid comparator, asynchronous.
  input wire logic b_sess_end_i, // B-device session end comparator, asynchronous.
  input wire logic stall_sent_i, // Pulse: STALL handshake sent.
  input wire logic token_done_i, // Pulse: token processing complete.
  input wire logic sof_i, // Pulse: SOF received or host SOF threshold.
  input wire logic [7:0] err_flags_i, // Error flag register contents.
  input wire logic [7:0] err_en_i, // Error enable register contents.
  output logic stat_advance_o, // Pulse: advance transfer-status FIFO.
  output logic irq_o // Level interrupt request.
);
  localparam int CW = uoi_pkg::CNT_W;
  localparam logic [CW-1:0] KS_C = CW'(KSTATE_CYC);
  localparam logic [CW-1:0] IDLE_C = CW'(IDLE_CYC);
  localparam logic [CW-1:0] MS_C = CW'(MS_CYC);
  localparam logic [CW-1:0] CNT_MAX = '1;

  if (IDLE_CYC >= 2 ** CW || MS_CYC >= 2 ** CW || KSTATE_CYC < 1 || MS_CYC < 1 ||
      IDLE_CYC < 1)
  begin : g_chk
    $error("Timing counts do not fit the line counter.");
  end

  typedef struct packed {
    logic ack;
    logic [7:0] dat;
    logic [1:0] ln_s1;
    logic [1:0] ln_s2;
    logic [3:0] otg_s1;
    logic [3:0] otg_s2;
    logic [3:0] otg_prev;
    logic [1:0] line_prev;
    logic [1:0] line_rec;
    logic [CW-1:0] cnt;
    logic [CW-1:0] ms_cnt;
    logic [7:0] otg_en;
    logic [7:0] otg_fl;
    logic [7:0] ev_en;
    logic [7:0] ev_fl;
    logic [7:0] ctl;
    logic err_sum;
    logic adv;
    logic irq;
  } uoi_state_t;

  uoi_state_t st_r;
  uoi_state_t st_nxt;

  logic host;
  logic [1:0] line;
  logic [1:0] j_line_state;
  logic [1:0] k_line_state;
  logic wr_req;
  logic rd_req;
  logic [7:0] wdat;
  logic [7:0] ev_rd;
  logic [7:0] en_rd;
  logic [7:0] ev_set;
  logic [7:0] otg_set;
  logic [3:0] otg_now;

  assign host = st_r.ctl[uoi_pkg::B_HOST_MODE];
  assign line = st_r.ln_s2;
  // Full speed idles with D+ high, low speed with D- high; K is the opposite.
  assign j_line_state = st_r.ctl[uoi_pkg::B_LOW_SPEED] ? uoi_pkg::LINE_DM : uoi_pkg::LINE_DP;
  assign k_line_state = st_r.ctl[uoi_pkg::B_LOW_SPEED] ? uoi_pkg::LINE_DP : uoi_pkg::LINE_DM;
  assign otg_now = st_r.otg_s2;
  assign wr_req = wb_cyc_i && wb_stb_i && !st_r.ack && wb_we_i && wb_sel_i[0];
  assign rd_req = wb_cyc_i && wb_stb_i && !st_r.ack && !wb_we_i;
  assign wdat = wb_dat_i[7:0];

  // Readable views: attach bits are hidden outside host mode.
  always_comb
  begin
    ev_rd = st_r.ev_fl;
    en_rd = st_r.ev_en;
    ev_rd[uoi_pkg::B_ERRSUM] = st_r.err_sum;
    if (!host)
    begin
      ev_rd[uoi_pkg::B_ATTACH] = 1'b0;
      en_rd[uoi_pkg::B_ATTACH] = 1'b0;
    end
  end

  // Hardware set terms for the event and OTG flags.
  always_comb
  begin
    ev_set = 8'h00;
    otg_set = 8'h00;
    ev_set[uoi_pkg::B_STALL] = stall_sent_i && !host;
    ev_set[uoi_pkg::B_RESUME] = line == k_line_state && st_r.cnt == KS_C;
    ev_set[uoi_pkg::B_IDLE] = line == j_line_state && st_r.cnt == IDLE_C;
    ev_set[uoi_pkg::B_TOKEN] = token_done_i;
    ev_set[uoi_pkg::B_SOF] = sof_i;
    // The counter passes the threshold once per SE0 episode, so the flag cannot
    // re-fire until SE0 has ended and started again.
    ev_set[uoi_pkg::B_RST_DET] = line == uoi_pkg::LINE_SE0 && st_r.cnt == KS_C;
    ev_set[uoi_pkg::B_ATTACH] = host && line != uoi_pkg::LINE_SE0 && st_r.cnt == KS_C;
    otg_set[uoi_pkg::B_ID] = otg_now[3] != st_r.otg_prev[3];
    otg_set[uoi_pkg::B_AVBUSVLD] = otg_now[2] != st_r.otg_prev[2];
    otg_set[uoi_pkg::B_SESSVLD] = otg_now[1] != st_r.otg_prev[1];
    otg_set[uoi_pkg::B_BSESSEND] = otg_now[0] != st_r.otg_prev[0];
    otg_set[uoi_pkg::B_ACTIVITY] = line != st_r.line_prev || otg_now != st_r.otg_prev;
    otg_set[uoi_pkg::B_MSTIMER] = st_r.ms_cnt == MS_C - CW'(1);
    otg_set[uoi_pkg::B_LSTABLE] = st_r.cnt == MS_C && line != st_r.line_rec;
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ln_s1 = {dp_i, dm_i};
    st_nxt.ln_s2 = st_r.ln_s1;
    st_nxt.otg_s1 = {id_i, a_vbus_vld_i, sess_vld_i, b_sess_end_i};
    st_nxt.otg_s2 = st_r.otg_s1;
    st_nxt.otg_prev = otg_now;
    st_nxt.line_prev = line;
    if (line != st_r.line_prev)
    begin
      st_nxt.cnt = '0;
    end
    else if (st_r.cnt != CNT_MAX)
    begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
    if (otg_set[uoi_pkg::B_LSTABLE])
    begin
      st_nxt.line_rec = line;
    end
    st_nxt.ms_cnt = otg_set[uoi_pkg::B_MSTIMER] ? '0 : st_r.ms_cnt + CW'(1);
    st_nxt.err_sum = |(err_flags_i & err_en_i);
    st_nxt.ack = wb_cyc_i && wb_stb_i && !st_r.ack;
    st_nxt.adv = 1'b0;
    // Set terms are merged after the clear so an event in the clearing cycle wins.
    st_nxt.ev_fl = st_r.ev_fl | ev_set;
    st_nxt.otg_fl = st_r.otg_fl | otg_set;
    if (wr_req)
    begin
      unique case (wb_adr_i)
        uoi_pkg::OFS_OTG_ENABLE: st_nxt.otg_en = wdat & uoi_pkg::OTG_MASK;
        uoi_pkg::OFS_OTG_STATUS:
          st_nxt.otg_fl = (st_r.otg_fl & ~wdat) | otg_set;
        uoi_pkg::OFS_EVENT_STATUS:
        begin
          st_nxt.ev_fl = (st_r.ev_fl & ~wdat) | ev_set;
          st_nxt.adv = wdat[uoi_pkg::B_TOKEN] && st_r.ev_fl[uoi_pkg::B_TOKEN];
        end
        uoi_pkg::OFS_EVENT_ENABLE: st_nxt.ev_en = wdat;
        uoi_pkg::OFS_CONTROL: st_nxt.ctl = wdat & uoi_pkg::CTL_MASK;
        default: st_nxt.ctl = st_r.ctl;
      endcase
    end
    st_nxt.ev_fl[uoi_pkg::B_ERRSUM] = 1'b0;
    st_nxt.otg_fl[1] = 1'b0;
    st_nxt.dat = 8'h00;
    if (rd_req)
    begin
      unique case (wb_adr_i)
        uoi_pkg::OFS_OTG_ENABLE: st_nxt.dat = st_r.otg_en;
        uoi_pkg::OFS_OTG_STATUS: st_nxt.dat = st_r.otg_fl;
        uoi_pkg::OFS_EVENT_STATUS: st_nxt.dat = ev_rd;
        uoi_pkg::OFS_EVENT_ENABLE: st_nxt.dat = en_rd;
        uoi_pkg::OFS_CONTROL: st_nxt.dat = st_r.ctl;
        default: st_nxt.dat = 8'h00;
      endcase
    end
    st_nxt.irq = |(ev_rd & en_rd) || |(st_r.otg_fl & st_r.otg_en);
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = {24'h000000, st_r.dat};
  assign wb_ack_o = st_r.ack;
  assign stat_advance_o = st_r.adv;
  assign irq_o = st_r.irq;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  sequence s_clear_token;
    s_req and (wb_we_i && wb_sel_i[0] && wb_adr_i == uoi_pkg::OFS_EVENT_STATUS &&
      wb_dat_i[uoi_pkg::B_TOKEN] && st_r.ev_fl[uoi_pkg::B_TOKEN]);
  endsequence

  property p_ack;
    s_req |=> s_ack_pulse;
  endproperty
  a_ack: assert property (p_ack) else $error("Ack not a single cycle after request.");

  property p_token_adv;
    s_clear_token |=> stat_advance_o ##1 !stat_advance_o;
  endproperty
  a_token_adv: assert property (p_token_adv) else $error("FIFO advance missing.");

  property p_keep_flag;
    st_r.ev_fl[uoi_pkg::B_STALL] && !(wr_req && wb_adr_i == uoi_pkg::OFS_EVENT_STATUS &&
      wdat[uoi_pkg::B_STALL]) |=> st_r.ev_fl[uoi_pkg::B_STALL];
  endproperty
  a_keep_flag: assert property (p_keep_flag) else $error("Flag lost without a one written.");

  property p_stall;
    stall_sent_i && !host |=> st_r.ev_fl[uoi_pkg::B_STALL];
  endproperty
  a_stall: assert property (p_stall) else $error("Stall event did not set its flag.");

  property p_reset_len;
    $rose(st_r.ev_fl[uoi_pkg::B_RST_DET]) |-> $past(line == uoi_pkg::LINE_SE0 &&
      st_r.cnt == KS_C);
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("Reset flag without long SE0.");

  property p_err_sum;
    ##1 st_r.err_sum == $past(|(err_flags_i & err_en_i));
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("Error summary disagrees with inputs.");

  property p_irq;
    irq_o |-> $past(|(ev_rd & en_rd) || |(st_r.otg_fl & st_r.otg_en));
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt without an enabled flag.");

  property p_attach_en_rd;
    (s_req and (!wb_we_i && wb_adr_i == uoi_pkg::OFS_EVENT_ENABLE && !host)) |=>
      wb_ack_o && !wb_dat_o[uoi_pkg::B_ATTACH];
  endproperty
  a_attach_en_rd: assert property (p_attach_en_rd) else $error("Attach enable visible.");

  property p_rsv;
    wb_dat_o[31:8] == 24'h000000 && !st_r.otg_en[1] && !st_r.otg_fl[1];
  endproperty
  a_rsv: assert property (p_rsv) else $error("Unimplemented bit is set.");

  property p_attach_dev;
    !host && $stable(host) |=> !$rose(st_r.ev_fl[uoi_pkg::B_ATTACH]);
  endproperty
  a_attach_dev: assert property (p_attach_dev) else $error("Attach set in device mode.");

  property p_sof;
    sof_i |=> st_r.ev_fl[uoi_pkg::B_SOF];
  endproperty
  a_sof: assert property (p_sof) else $error("Frame start event did not set its flag.");

  property p_token_set;
    token_done_i |=> st_r.ev_fl[uoi_pkg::B_TOKEN];
  endproperty
  a_token_set: assert property (p_token_set) else $error("Token event did not set its flag.");

  property p_otg_en_wr;
    wr_req && wb_adr_i == uoi_pkg::OFS_OTG_ENABLE |=>
      st_r.otg_en == ($past(wdat) & uoi_pkg::OTG_MASK);
  endproperty
  a_otg_en_wr: assert property (p_otg_en_wr) else $error("OTG enable write lost.");

  property p_ev_en_wr;
    wr_req && wb_adr_i == uoi_pkg::OFS_EVENT_ENABLE |=> st_r.ev_en == $past(wdat);
  endproperty
  a_ev_en_wr: assert property (p_ev_en_wr) else $error("Event enable write lost.");

  property p_clear;
    wr_req && wb_adr_i == uoi_pkg::OFS_EVENT_STATUS && wdat[uoi_pkg::B_IDLE] &&
      !ev_set[uoi_pkg::B_IDLE] |=> !st_r.ev_fl[uoi_pkg::B_IDLE];
  endproperty
  a_clear: assert property (p_clear) else $error("Writing one did not clear a flag.");

  property p_keep_otg;
    st_r.otg_fl[uoi_pkg::B_ID] && !(wr_req && wb_adr_i == uoi_pkg::OFS_OTG_STATUS &&
      wdat[uoi_pkg::B_ID]) |=> st_r.otg_fl[uoi_pkg::B_ID];
  endproperty
  a_keep_otg: assert property (p_keep_otg) else $error("OTG flag lost without a one.");

  property p_resume;
    $rose(st_r.ev_fl[uoi_pkg::B_RESUME]) |-> $past(line == k_line_state && st_r.cnt == KS_C);
  endproperty
  a_resume: assert property (p_resume) else $error("Resume flag without a long K state.");

  property p_idle;
    $rose(st_r.ev_fl[uoi_pkg::B_IDLE]) |-> $past(line == j_line_state && st_r.cnt == IDLE_C);
  endproperty
  a_idle: assert property (p_idle) else $error("Idle flag without a long idle state.");

  property p_attach_host;
    $rose(st_r.ev_fl[uoi_pkg::B_ATTACH]) |->
      $past(host && line != uoi_pkg::LINE_SE0 && st_r.cnt == KS_C);
  endproperty
  a_attach_host: assert property (p_attach_host) else $error("Attach flag without quiet bus.");

  property p_ms_timer;
    $rose(st_r.otg_fl[uoi_pkg::B_MSTIMER]) |-> $past(st_r.ms_cnt == MS_C - CW'(1));
  endproperty
  a_ms_timer: assert property (p_ms_timer) else $error("Timer flag before the period ended.");

  property p_adv_cause;
    stat_advance_o |-> $past(wr_req && wb_adr_i == uoi_pkg::OFS_EVENT_STATUS &&
      wdat[uoi_pkg::B_TOKEN]);
  endproperty
  a_adv_cause: assert property (p_adv_cause) else $error("FIFO advance without a clear.");

  property p_irq_on;
    |(ev_rd & en_rd) |=> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("Enabled flag raised no interrupt.");

  property p_irq_off;
    !(|(ev_rd & en_rd)) && !(|(st_r.otg_fl & st_r.otg_en)) |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("Interrupt with no enabled flag.");

  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h00000000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("Read data outside an answer.");

  property p_errsum_ro;
    !st_r.ev_fl[uoi_pkg::B_ERRSUM];
  endproperty
  a_errsum_ro: assert property (p_errsum_ro) else $error("Error summary stored as a flag.");
endmodule // uoi_flags
`default_nettype wire

// File: uoi_flags_bench.sv
// Self-checking bench of the USB OTG interrupt flag block.
`timescale 1ns/1ps
`default_nettype none
module uoi_flags_bench;
  localparam int KS = 8;
  localparam int IDL = 400;
  localparam int MSC = 300;
  typedef struct packed {logic [7:0] adr; logic [31:0] wd; logic [7:0] rd;} uoi_row_t;
  logic core_clk, rst_b, cyc, stb, we, ack, adv, adv_seen, irq, id, dp, dm;
  logic [7:0] adr, eflg, een;
  logic [3:0] sel;
  logic [31:0] wd, rdat, q;
  logic [2:0] ev;
  logic [1:0] lc;
  int errors, compares, ticks;
  uoi_row_t rows [5];
  uoi_flags #(.IDLE_CYC(IDL), .MS_CYC(MSC), .KSTATE_CYC(KS)) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .dp_i(dp), .dm_i(dm), .id_i(id), .a_vbus_vld_i(1'b0), .sess_vld_i(1'b0),
    .b_sess_end_i(1'b0), .stall_sent_i(ev[0]), .token_done_i(ev[1]), .sof_i(ev[2]),
    .err_flags_i(eflg), .err_en_i(een), .stat_advance_o(adv), .irq_o(irq));
  uoi_line_model i_line (.line_cmd(lc), .dp(dp), .dm(dm));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Classic cycle: hold everything until ack is sampled high, then release.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge core_clk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("ack", 32'h1, {31'h0, ack});
    q = rdat;
    adv_seen = adv;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk("read", {24'h0, e & m}, q & {24'hFFFFFF, m});
  endtask
  task automatic pulse(input logic [2:0] p);
    ev <= p;
    @(posedge core_clk);
    ev <= 3'h0;
    @(posedge core_clk);
  endtask
  task automatic hold(input logic [1:0] c, input int n);
    lc <= c;
    repeat (n) @(posedge core_clk);
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    ticks++;
    if (ticks == 30000)
    begin
      errors++;
      end_of_test();
    end
  end
  initial
  begin
    {rst_b, cyc, stb, we, id, adr, wd, ev, lc, eflg, een} = '0;
    sel = 4'hF;
    rows[0] = '{8'h00, 32'hFFFF_FFFF, 8'hFD};
    rows[1] = '{8'h00, 32'h0, 8'h00};
    rows[2] = '{8'h0C, 32'hFFFF_FFFF, 8'hBF};
    rows[3] = '{8'h0C, 32'h0, 8'h00};
    rows[4] = '{8'h20, 32'hFF, 8'h00};
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i])
    begin
      wr(rows[i].adr, rows[i].wd);
      rd(rows[i].adr, 8'hFF, rows[i].rd);
    end
    wr(8'h0C, 32'h8E);
    pulse(3'h1);
    rd(8'h08, 8'h80, 8'h80);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h08, 32'h0);
    rd(8'h08, 8'h80, 8'h80);
    wr(8'h08, 32'h80);
    rd(8'h08, 8'h80, 8'h00);
    chk("irq", 32'h0, {31'h0, irq});
    pulse(3'h2);
    rd(8'h08, 8'h08, 8'h08);
    wr(8'h08, 32'h08);
    chk("advance", 32'h1, {31'h0, adv_seen});
    wr(8'h08, 32'h08);
    chk("advance", 32'h0, {31'h0, adv_seen});
    pulse(3'h4);
    rd(8'h08, 8'h04, 8'h04);
    wr(8'h08, 32'h04);
    eflg <= 8'h21;
    een <= 8'h40;
    repeat (2) @(posedge core_clk);
    rd(8'h08, 8'h02, 8'h00);
    een <= 8'h20;
    repeat (2) @(posedge core_clk);
    rd(8'h08, 8'h02, 8'h02);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h08, 32'h02);
    rd(8'h08, 8'h02, 8'h02);
    eflg <= 8'h00;
    repeat (2) @(posedge core_clk);
    rd(8'h08, 8'h02, 8'h00);
    hold(2'h1, KS / 2);
    hold(2'h0, 4);
    rd(8'h08, 8'h20, 8'h00);
    hold(2'h1, KS + 10);
    hold(2'h0, 2);
    rd(8'h08, 8'h20, 8'h20);
    hold(2'h2, KS + 10);
    rd(8'h08, 8'h01, 8'h01);
    wr(8'h08, 32'h11);
    hold(2'h2, KS + 10);
    rd(8'h08, 8'h11, 8'h00);
    hold(2'h0, IDL / 2);
    rd(8'h08, 8'h10, 8'h00);
    hold(2'h0, IDL);
    rd(8'h08, 8'h10, 8'h10);
    id <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(8'h04, 8'h80, 8'h80);
    wr(8'h00, 32'h80);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h04, 32'hFF);
    wr(8'h00, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    hold(2'h0, MSC + 10);
    rd(8'h04, 8'h40, 8'h40);
    wr(8'h10, 32'h1);
    wr(8'h0C, 32'hFF);
    rd(8'h0C, 8'hFF, 8'hFF);
    sel <= 4'hE;
    wr(8'h0C, 32'h0);
    sel <= 4'hF;
    rd(8'h0C, 8'hFF, 8'hFF);
    hold(2'h2, KS + 10);
    hold(2'h0, KS + 10);
    rd(8'h08, 8'h41, 8'h41);
    wr(8'h08, 32'h20);
    wr(8'h10, 32'h3);
    hold(2'h1, 4);
    hold(2'h0, KS + 10);
    hold(2'h1, 2);
    rd(8'h08, 8'h20, 8'h20);
    id <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h00, 8'hFF, 8'h00);
    rd(8'h08, 8'hFF, 8'h00);
    rd(8'h0C, 8'hFF, 8'h00);
    rd(8'h10, 8'hFF, 8'h00);
    end_of_test();
  end
endmodule // uoi_flags_bench
`default_nettype wire

// File: uoi_line_model.sv
// Behavioural USB line partner that drives D+ and D- on command of the bench.
`timescale 1ns/1ps
`default_nettype none
module uoi_line_model (
  input wire logic [1:0] line_cmd, // Line state to show: 0 J, 1 K, 2 SE0.
  output logic dp, // D+ level.
  output logic dm // D- level.
);
  // Full speed is assumed, so J is D+ high and K is D- high.
  always_comb
  begin
    case (line_cmd)
      2'h0: {dp, dm} = uoi_pkg::LINE_DP;
      2'h1: {dp, dm} = uoi_pkg::LINE_DM;
      default: {dp, dm} = uoi_pkg::LINE_SE0;
    endcase
  end
endmodule // uoi_line_model
`default_nettype wire

// File: uoi_pkg.sv
// Shared constants of the USB OTG interrupt flag block.
package uoi_pkg;
  // Register byte addresses on the bus.
  localparam logic [7:0] OFS_OTG_ENABLE = 8'h00;
  localparam logic [7:0] OFS_OTG_STATUS = 8'h04;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVENT_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  // Event status and enable bit positions.
  localparam int B_STALL = 7;
  localparam int B_ATTACH = 6;
  localparam int B_RESUME = 5;
  localparam int B_IDLE = 4;
  localparam int B_TOKEN = 3;
  localparam int B_SOF = 2;
  localparam int B_ERRSUM = 1;
  localparam int B_RST_DET = 0;
  // OTG status and enable bit positions.
  localparam int B_ID = 7;
  localparam int B_MSTIMER = 6;
  localparam int B_LSTABLE = 5;
  localparam int B_ACTIVITY = 4;
  localparam int B_SESSVLD = 3;
  localparam int B_BSESSEND = 2;
  localparam int B_AVBUSVLD = 0;
  // Control register bit positions.
  localparam int B_HOST_MODE = 0;
  localparam int B_LOW_SPEED = 1;
  // Writable masks; unimplemented bits stay zero.
  localparam logic [7:0] OTG_MASK = 8'hFD;
  localparam logic [7:0] CTL_MASK = 8'h03;
  // Reset values.
  localparam logic [7:0] RST_REG = 8'h00;
  // Line states as {dp, dm}.
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_DP = 2'h2;
  localparam logic [1:0] LINE_DM = 2'h1;
  // Timing.
  localparam int CLK_MHZ = 200;
  localparam int T_KSTATE_NS = 2500;
  localparam int T_IDLE_NS = 3000000;
  localparam int T_MS_NS = 1000000;
  localparam int KSTATE_CYC = (T_KSTATE_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_CYC = (T_IDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int MS_CYC = (T_MS_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 20;
endpackage
